//--- core/pcg_top.sv
// Purpose: pll clock generator with bypass, dividers and pin gating
// Assumes: apb slave on clk; pll_ref_tick comes from pll logic on clk
// Notes: generated clocks are flop waveforms toggling on ref ticks
`timescale 1ns/1ps
module pcg_top #(
    parameter int LOCK_CYCLES = pcg_pkg::PLL_LOCK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pll side
    input wire logic pll_ref_tick,
    output logic pll_reset_out,
    output logic pll_ref_clock,
    // generated clocks
    output logic core_clock,
    output logic periph_bus_clock,
    output logic mem_iface_clock,
    // pins
    input wire logic mem_clock_in_pin,
    output logic bus_clock_out_pin,
    output logic bus_clock_out_oe,
    output logic osc_clock_out_pin,
    output logic osc_clock_out_oe,
    output logic mem_clock_out_pin,
    output logic mem_clock_out_oe
);

    // software-visible control
    logic path_select_q;
    logic pll_reset_q;
    logic [4:0] pre_ratio_q;
    logic [4:0] core_ratio_q;
    logic [4:0] periph_ratio_q;
    logic [4:0] mem_ratio_q;
    logic [4:0] osc_ratio_q;
    logic pre_en_q;
    logic core_en_q;
    logic periph_en_q;
    logic mem_en_q;
    logic osc_en_q;
    logic mem_src_sel_q;
    logic bus_out_en_q;
    logic mem_out_en_q;
    // pll sequencing
    logic [pcg_pkg::CNT_W-1:0] rst_cnt_q;
    logic [pcg_pkg::CNT_W-1:0] lock_cnt_q;
    logic reset_time_met_q;
    logic pll_locked_q;
    logic ref_sel_q;
    // internal clocks
    logic ref_tick;
    logic core_clk;
    logic core_tick;
    logic periph_clk;
    logic mem_clk;
    logic osc_clk;
    logic pre_clk;
    logic bus_gate_q;
    logic osc_gate_q;
    // bus decode
    logic access;
    logic wr_commit;
    logic [7:0] offset;
    logic mapped;
    logic [31:0] rd_word;

    // divider register image
    function automatic logic [31:0] div_word(input logic en, input logic [4:0] ratio);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[pcg_pkg::BIT_DIV_ENABLE] = en;
        w[pcg_pkg::RATIO_W-1:0] = ratio;
        return w;
    endfunction : div_word

    ////////////////////////////////////////////////////////////////////////
    // apb decode: one wait state, write lands when pready is seen
    assign access = psel & penable;
    assign wr_commit = access & pready & pwrite;
    assign offset = paddr[7:0];
    assign mapped = (paddr[31:8] == 24'h00_0000) && (offset[1:0] == 2'b00) && (offset <= pcg_pkg::OFF_MEM_GLOBAL_CTRL);

    // read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (offset)
            pcg_pkg::OFF_PLL_CSR: begin
                rd_word[pcg_pkg::BIT_PATH_SELECT] = path_select_q;
                rd_word[pcg_pkg::BIT_PLL_RESET] = pll_reset_q;
                rd_word[pcg_pkg::BIT_RESET_TIME_MET] = reset_time_met_q;
                rd_word[pcg_pkg::BIT_PLL_LOCKED] = pll_locked_q;
            end
            pcg_pkg::OFF_PRESCALER: rd_word = div_word(pre_en_q, pre_ratio_q);
            pcg_pkg::OFF_CORE_DIV: rd_word = div_word(core_en_q, core_ratio_q);
            pcg_pkg::OFF_PERIPH_DIV: rd_word = div_word(periph_en_q, periph_ratio_q);
            pcg_pkg::OFF_MEM_DIV: rd_word = div_word(mem_en_q, mem_ratio_q);
            pcg_pkg::OFF_OSC_DIV: rd_word = div_word(osc_en_q, osc_ratio_q);
            pcg_pkg::OFF_DEVICE_CONFIG: rd_word[pcg_pkg::BIT_MEM_SRC_SEL] = mem_src_sel_q;
            pcg_pkg::OFF_MEM_GLOBAL_CTRL: begin
                rd_word[pcg_pkg::BIT_BUS_OUT_EN] = bus_out_en_q;
                rd_word[pcg_pkg::BIT_MEM_OUT_EN] = mem_out_en_q;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // answer registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= access & ~pready;
            pslverr <= access & ~pready & ~mapped;
            if (access && !pready) begin
                prdata <= mapped ? rd_word : 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            path_select_q <= pcg_pkg::RST_PATH_SELECT;
            pll_reset_q <= pcg_pkg::RST_PLL_RESET;
            mem_src_sel_q <= pcg_pkg::RST_MEM_SRC_SEL;
            bus_out_en_q <= pcg_pkg::RST_BUS_OUT_EN;
            mem_out_en_q <= pcg_pkg::RST_MEM_OUT_EN;
        end else if (wr_commit && mapped) begin
            if (offset == pcg_pkg::OFF_PLL_CSR) begin
                path_select_q <= pwdata[pcg_pkg::BIT_PATH_SELECT];
                pll_reset_q <= pwdata[pcg_pkg::BIT_PLL_RESET];
            end
            if (offset == pcg_pkg::OFF_DEVICE_CONFIG) begin
                mem_src_sel_q <= pwdata[pcg_pkg::BIT_MEM_SRC_SEL];
            end
            if (offset == pcg_pkg::OFF_MEM_GLOBAL_CTRL) begin
                bus_out_en_q <= pwdata[pcg_pkg::BIT_BUS_OUT_EN];
                mem_out_en_q <= pwdata[pcg_pkg::BIT_MEM_OUT_EN];
            end
        end
    end

    // divider register writes; software must keep core and bus enabled
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pre_ratio_q <= pcg_pkg::RST_PRESCALER_RATIO;
            core_ratio_q <= pcg_pkg::RST_CORE_RATIO;
            periph_ratio_q <= pcg_pkg::RST_PERIPH_RATIO;
            mem_ratio_q <= pcg_pkg::RST_MEM_RATIO;
            osc_ratio_q <= pcg_pkg::RST_OSC_RATIO;
            pre_en_q <= pcg_pkg::RST_DIV_ENABLE;
            core_en_q <= pcg_pkg::RST_DIV_ENABLE;
            periph_en_q <= pcg_pkg::RST_DIV_ENABLE;
            mem_en_q <= pcg_pkg::RST_DIV_ENABLE;
            osc_en_q <= pcg_pkg::RST_DIV_ENABLE;
        end else if (wr_commit && mapped) begin
            unique case (offset)
                pcg_pkg::OFF_PRESCALER: begin
                    pre_ratio_q <= pwdata[pcg_pkg::RATIO_W-1:0];
                    pre_en_q <= pwdata[pcg_pkg::BIT_DIV_ENABLE];
                end
                pcg_pkg::OFF_CORE_DIV: begin
                    core_ratio_q <= pwdata[pcg_pkg::RATIO_W-1:0];
                    core_en_q <= pwdata[pcg_pkg::BIT_DIV_ENABLE];
                end
                pcg_pkg::OFF_PERIPH_DIV: begin
                    periph_ratio_q <= pwdata[pcg_pkg::RATIO_W-1:0];
                    periph_en_q <= pwdata[pcg_pkg::BIT_DIV_ENABLE];
                end
                pcg_pkg::OFF_MEM_DIV: begin
                    mem_ratio_q <= pwdata[pcg_pkg::RATIO_W-1:0];
                    mem_en_q <= pwdata[pcg_pkg::BIT_DIV_ENABLE];
                end
                pcg_pkg::OFF_OSC_DIV: begin
                    osc_ratio_q <= pwdata[pcg_pkg::RATIO_W-1:0];
                    osc_en_q <= pwdata[pcg_pkg::BIT_DIV_ENABLE];
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pll reset hold time: status only, the wait is software's job
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rst_cnt_q <= '0;
            reset_time_met_q <= 1'b0;
        end else if (!pll_reset_q) begin
            rst_cnt_q <= '0;
        end else if (rst_cnt_q < pcg_pkg::CNT_W'(pcg_pkg::PLL_RESET_CYCLES)) begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
        end else begin
            reset_time_met_q <= 1'b1;
        end
    end

    // lock timer from reset release, max lock time budgeted
    always_ff @(posedge clk) begin
        if (sys_rst || pll_reset_q) begin
            lock_cnt_q <= '0;
            pll_locked_q <= 1'b0;
        end else if (lock_cnt_q < pcg_pkg::CNT_W'(LOCK_CYCLES)) begin
            lock_cnt_q <= lock_cnt_q + 1'b1;
        end else begin
            pll_locked_q <= 1'b1;
        end
    end

    // reference source follows path select at a core clock edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ref_sel_q <= pcg_pkg::RST_PATH_SELECT;
        end else if (core_tick) begin
            ref_sel_q <= path_select_q;
        end
    end

    // bypass ticks every cycle, pll path ticks from pll output
    assign ref_tick = ref_sel_q ? pll_ref_tick : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // prescaler ahead of the pll, fed straight from the input clock
    pcg_clk_div u_pre_div (
        .clk(clk), .sys_rst(sys_rst), .tick(1'b1), .ratio(pre_ratio_q), .enable(pre_en_q),
        .rst_ratio(pcg_pkg::RST_PRESCALER_RATIO), .div_clk_q(pre_clk), .div_tick_q()
    );

    // system dividers on the selected reference
    pcg_clk_div u_core_div (
        .clk(clk), .sys_rst(sys_rst), .tick(ref_tick), .ratio(core_ratio_q), .enable(core_en_q),
        .rst_ratio(pcg_pkg::RST_CORE_RATIO), .div_clk_q(core_clk), .div_tick_q(core_tick)
    );
    pcg_clk_div u_periph_div (
        .clk(clk), .sys_rst(sys_rst), .tick(ref_tick), .ratio(periph_ratio_q), .enable(periph_en_q),
        .rst_ratio(pcg_pkg::RST_PERIPH_RATIO), .div_clk_q(periph_clk), .div_tick_q()
    );
    pcg_clk_div u_mem_div (
        .clk(clk), .sys_rst(sys_rst), .tick(ref_tick), .ratio(mem_ratio_q), .enable(mem_en_q),
        .rst_ratio(pcg_pkg::RST_MEM_RATIO), .div_clk_q(mem_clk), .div_tick_q()
    );

    // oscillator output divider on the raw input clock
    pcg_clk_div u_osc_div (
        .clk(clk), .sys_rst(sys_rst), .tick(1'b1), .ratio(osc_ratio_q), .enable(osc_en_q),
        .rst_ratio(pcg_pkg::RST_OSC_RATIO), .div_clk_q(osc_clk), .div_tick_q()
    );

    ////////////////////////////////////////////////////////////////////////
    // pin gates move only while their clock is low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_gate_q <= 1'b1;
            osc_gate_q <= 1'b1;
        end else begin
            if (!periph_clk) begin
                bus_gate_q <= periph_en_q & bus_out_en_q;
            end
            if (!osc_clk) begin
                osc_gate_q <= osc_en_q;
            end
        end
    end

    // registered clock and pin outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pll_reset_out <= pcg_pkg::RST_PLL_RESET;
            pll_ref_clock <= 1'b0;
            core_clock <= 1'b0;
            periph_bus_clock <= 1'b0;
            mem_iface_clock <= 1'b0;
            bus_clock_out_pin <= 1'b0;
            bus_clock_out_oe <= 1'b0;
            osc_clock_out_pin <= 1'b0;
            osc_clock_out_oe <= 1'b0;
        end else begin
            pll_reset_out <= pll_reset_q;
            pll_ref_clock <= pre_clk;
            core_clock <= core_clk;
            periph_bus_clock <= periph_clk;
            mem_iface_clock <= mem_clk;
            bus_clock_out_pin <= periph_clk & bus_gate_q;
            bus_clock_out_oe <= bus_gate_q;
            osc_clock_out_pin <= osc_clk & osc_gate_q;
            osc_clock_out_oe <= osc_gate_q;
        end
    end

    // memory pin: internal or external source, gated
    pcg_clk_sel u_mem_sel (
        .clk(clk), .sys_rst(sys_rst), .int_clk(mem_clk), .ext_pin(mem_clock_in_pin),
        .sel(mem_src_sel_q), .out_en(mem_out_en_q), .out_q(mem_clock_out_pin), .oe_q(mem_clock_out_oe)
    );

endmodule : pcg_top

//--- inc/pcg_pkg.sv
// Purpose: shared constants of the pll clock generator
// Assumes: apb data 32 bits, one aligned word per register
// Notes: divider ratio field n means n+1 ticks per half period
package pcg_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_PLL_CSR = 8'h00;
    localparam logic [7:0] OFF_PRESCALER = 8'h04;
    localparam logic [7:0] OFF_CORE_DIV = 8'h08;
    localparam logic [7:0] OFF_PERIPH_DIV = 8'h0C;
    localparam logic [7:0] OFF_MEM_DIV = 8'h10;
    localparam logic [7:0] OFF_OSC_DIV = 8'h14;
    localparam logic [7:0] OFF_DEVICE_CONFIG = 8'h18;
    localparam logic [7:0] OFF_MEM_GLOBAL_CTRL = 8'h1C;

    // field positions
    localparam int BIT_PATH_SELECT = 0;
    localparam int BIT_PLL_RESET = 3;
    localparam int BIT_RESET_TIME_MET = 5;
    localparam int BIT_PLL_LOCKED = 6;
    localparam int BIT_DIV_ENABLE = 15;
    localparam int BIT_MEM_SRC_SEL = 4;
    localparam int BIT_BUS_OUT_EN = 3;
    localparam int BIT_MEM_OUT_EN = 5;
    localparam int RATIO_W = 5;

    // values after reset
    localparam logic RST_PATH_SELECT = 1'b0;
    localparam logic RST_PLL_RESET = 1'b1;
    localparam logic RST_DIV_ENABLE = 1'b1;
    localparam logic RST_MEM_SRC_SEL = 1'b0;
    localparam logic RST_BUS_OUT_EN = 1'b1;
    localparam logic RST_MEM_OUT_EN = 1'b1;
    localparam logic [4:0] RST_PRESCALER_RATIO = 5'h00;
    localparam logic [4:0] RST_CORE_RATIO = 5'h00;
    localparam logic [4:0] RST_PERIPH_RATIO = 5'h01;
    localparam logic [4:0] RST_MEM_RATIO = 5'h01;
    localparam logic [4:0] RST_OSC_RATIO = 5'h07;

    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int PLL_RESET_TIME_NS = 125;
    localparam int PLL_LOCK_TIME_NS = 187500;
    localparam int PLL_RESET_CYCLES = (PLL_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PLL_LOCK_CYCLES = (PLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 14;

endpackage : pcg_pkg

//--- core/pcg_clk_div.sv
// Purpose: 50 percent duty divider on reference half-period ticks
// Assumes: tick is a one-cycle pulse on clk
// Notes: new ratio taken only at a toggle, stops only when low
`timescale 1ns/1ps
module pcg_clk_div (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire logic tick,
    input wire logic [4:0] ratio,
    input wire logic enable,
    input wire logic [4:0] rst_ratio,
    // divided clock
    output logic div_clk_q,
    output logic div_tick_q
);

    logic [4:0] count_q;
    logic [4:0] ratio_q;

    ////////////////////////////////////////////////////////////////////////
    // count ticks, toggle at end of half period
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_q <= 5'h00;
            ratio_q <= rst_ratio;
            div_clk_q <= 1'b0;
            div_tick_q <= 1'b0;
        end else begin
            div_tick_q <= 1'b0;
            // running low and disabled: park, so no runt high phase
            if (tick && (enable || div_clk_q)) begin
                if (count_q >= ratio_q) begin
                    count_q <= 5'h00;
                    ratio_q <= ratio;
                    div_clk_q <= ~div_clk_q;
                    div_tick_q <= 1'b1;
                end else begin
                    count_q <= count_q + 5'h01;
                end
            end
        end
    end

endmodule : pcg_clk_div

//--- core/pcg_clk_sel.sv
// Purpose: glitch-free two-source clock select with output gate
// Assumes: ext_pin is asynchronous, int_clk is a flop on clk
// Notes: select and enable change only while the clocks are low
`timescale 1ns/1ps
module pcg_clk_sel (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // sources
    input wire logic int_clk,
    input wire logic ext_pin,
    // control
    input wire logic sel,
    input wire logic out_en,
    // pin
    output logic out_q,
    output logic oe_q
);

    logic ext_meta_q;
    logic ext_sync_q;
    logic sel_q;
    logic en_q;
    logic src;

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchroniser for the external memory clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
        end else begin
            ext_meta_q <= ext_pin;
            ext_sync_q <= ext_meta_q;
        end
    end

    // switch only with both sources low, so no short pulse
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sel_q <= pcg_pkg::RST_MEM_SRC_SEL;
        end else if (!int_clk && !ext_sync_q) begin
            sel_q <= sel;
        end
    end

    assign src = sel_q ? ext_sync_q : int_clk;

    // gate the pin while the selected source is low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_q <= pcg_pkg::RST_MEM_OUT_EN;
        end else if (!src) begin
            en_q <= out_en;
        end
    end

    // registered pin and drive enable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            out_q <= src & en_q;
            oe_q <= en_q;
        end
    end

endmodule : pcg_clk_sel

//--- verif/pcg_top_assertions.sv
// Purpose: port-level checks of the pll clock generator
// Assumes: one clock domain, synchronous active-high reset
// Notes: bus phase check relies on the bus ratio field kept at one or more
`timescale 1ns/1ps
module pcg_top_assertions #(
    parameter int LOCK_CYCLES = pcg_pkg::PLL_LOCK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // clocks and pins
    input wire logic pll_reset_out,
    input wire logic periph_bus_clock,
    input wire logic bus_clock_out_pin,
    input wire logic bus_clock_out_oe,
    input wire logic osc_clock_out_pin,
    input wire logic osc_clock_out_oe,
    input wire logic mem_clock_out_pin,
    input wire logic mem_clock_out_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////
    // apb answer: one wait cycle, one-cycle pulse
    property p_ready_next;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("pready missing after access");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");

    ////////////////////////////////////////////////////////////
    // pll held in reset until software clears the bit
    property p_rst_held;
        $fell(sys_rst) |-> pll_reset_out;
    endproperty
    a_rst_held: assert property (p_rst_held) else $error("pll not held after reset");
    sequence s_csr_release;
        psel && penable && pready && pwrite && !pslverr && paddr == 32'h0 && !pwdata[3];
    endsequence
    property p_rst_release;
        s_csr_release |-> ##[1:2] !pll_reset_out;
    endproperty
    a_rst_release: assert property (p_rst_release) else $error("pll reset not released");

    ////////////////////////////////////////////////////////////
    // pin gating; pins idle low while not driven
    property p_gates_up;
        $fell(sys_rst) |-> ##[1:4] (bus_clock_out_oe && osc_clock_out_oe && mem_clock_out_oe);
    endproperty
    a_gates_up: assert property (p_gates_up) else $error("pins not enabled after reset");
    property p_bus_pin;
        bus_clock_out_pin |-> bus_clock_out_oe;
    endproperty
    a_bus_pin: assert property (p_bus_pin) else $error("bus pin high while undriven");
    property p_osc_pin;
        osc_clock_out_pin |-> osc_clock_out_oe;
    endproperty
    a_osc_pin: assert property (p_osc_pin) else $error("osc pin high while undriven");
    property p_mem_pin;
        mem_clock_out_pin |-> mem_clock_out_oe;
    endproperty
    a_mem_pin: assert property (p_mem_pin) else $error("mem pin high while undriven");
    // a bus phase below two cycles means a shortened pulse
    property p_bus_phase;
        $changed(periph_bus_clock) |=> $stable(periph_bus_clock);
    endproperty
    a_bus_phase: assert property (p_bus_phase) else $error("short bus clock phase");

    ////////////////////////////////////////////////////////////
    // main scenarios reached
    c_pll_release: cover property ($fell(pll_reset_out));
    c_unmapped: cover property (pslverr);
    c_mem_pin: cover property ($rose(mem_clock_out_pin));
    c_bus_gate: cover property ($fell(bus_clock_out_oe));
endmodule : pcg_top_assertions

bind pcg_top pcg_top_assertions #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (.clk, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .pll_reset_out, .periph_bus_clock, .bus_clock_out_pin,
    .bus_clock_out_oe, .osc_clock_out_pin, .osc_clock_out_oe, .mem_clock_out_pin, .mem_clock_out_oe);

//--- verif/pcg_pll_model.sv
// Purpose: behavioural pll giving reference ticks to the generator
// Assumes: ticks on clk, one tick per pll half period
// Notes: silent while in reset and until the lock count has run
`timescale 1ns/1ps
module pcg_pll_model #(
    parameter int LOCK_CYCLES = 20,
    parameter int TICK_GAP = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // pll control and output
    input wire logic pll_reset_out,
    output logic pll_ref_tick
);
    int lock_q;
    int gap_q;
    // no ticks before lock: an early switch would see a dead clock
    always_ff @(posedge clk) begin
        if (sys_rst || pll_reset_out) begin
            lock_q <= 0;
            gap_q <= 0;
            pll_ref_tick <= 1'b0;
        end else if (lock_q < LOCK_CYCLES) begin
            lock_q <= lock_q + 1;
            pll_ref_tick <= 1'b0;
        end else begin
            gap_q <= (gap_q == TICK_GAP - 1) ? 0 : gap_q + 1;
            pll_ref_tick <= (gap_q == TICK_GAP - 1);
        end
    end
endmodule : pcg_pll_model

//--- verif/pcg_top_bench.sv
// Purpose: register, gating and clock period tests of the generator
// Assumes: apb slave answers after one wait cycle; short lock count
// Notes: periods measured rise to rise in clk cycles
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("Error %0t: got %h want %h", $time, a, b); end end
module pcg_top_bench;
    localparam int LOCK = 20;
    localparam int GAP = 3;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic pll_ref_tick, pll_reset_out, pll_ref_clock, ext_clk = 1'b0, core_clock, periph_bus_clock, mem_iface_clock;
    logic bus_clock_out_pin, bus_clock_out_oe, osc_clock_out_pin, osc_clock_out_oe;
    logic mem_clock_out_pin, mem_clock_out_oe;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [9:0] watch;
    int fails, n_tests, p, ext_n = 0;
    logic [7:0] offs [8] = '{pcg_pkg::OFF_PLL_CSR, pcg_pkg::OFF_PRESCALER, pcg_pkg::OFF_CORE_DIV,
        pcg_pkg::OFF_PERIPH_DIV, pcg_pkg::OFF_MEM_DIV, pcg_pkg::OFF_OSC_DIV, pcg_pkg::OFF_DEVICE_CONFIG,
        pcg_pkg::OFF_MEM_GLOBAL_CTRL};
    logic [31:0] rvals [8] = '{32'h8, 32'h8000, 32'h8000, 32'h8001, 32'h8001, 32'h8007, 32'h0, 32'h28};
    int psel_t [6] = '{0, 2, 3, 4, 5, 9};
    int pexp_t [6] = '{2, 4, 4, 16, 4, 2};
    logic [7:0] goff [3] = '{pcg_pkg::OFF_MEM_GLOBAL_CTRL, pcg_pkg::OFF_OSC_DIV, pcg_pkg::OFF_MEM_GLOBAL_CTRL};
    logic [31:0] gval [3] = '{32'h20, 32'h7, 32'h8};
    logic [31:0] grest [3] = '{32'h28, 32'h8007, 32'h28};

    ////////////////////////////////////////////////////////////
    // design and pll model
    assign watch = {pll_ref_clock, mem_clock_out_oe, osc_clock_out_oe, bus_clock_out_oe, mem_clock_out_pin,
        osc_clock_out_pin, bus_clock_out_pin, mem_iface_clock, periph_bus_clock, core_clock};
    pcg_top #(.LOCK_CYCLES(LOCK)) dut_u (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pll_ref_tick, .pll_reset_out, .pll_ref_clock, .core_clock,
        .periph_bus_clock, .mem_iface_clock, .mem_clock_in_pin(ext_clk), .bus_clock_out_pin,
        .bus_clock_out_oe, .osc_clock_out_pin, .osc_clock_out_oe, .mem_clock_out_pin, .mem_clock_out_oe);
    pcg_pll_model #(.LOCK_CYCLES(LOCK), .TICK_GAP(GAP)) pll_u (.clk, .sys_rst, .pll_reset_out, .pll_ref_tick);

    ////////////////////////////////////////////////////////////
    // clock, and external memory clock of period 10
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        ext_n <= (ext_n == 4) ? 0 : ext_n + 1;
        if (ext_n == 4) ext_clk <= ~ext_clk;
    end

    ////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    // one transfer; request held until pready sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h000000, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK(pready, 1'b1)
        if (pready !== 1'b1) finish_test();
    endtask : apb

    // bounded wait for a watched level, adding cycles spent to p
    task automatic wait_lvl(input int s, input logic v);
        int k;
        k = 0;
        while (watch[s] !== v && k < 200) begin
            @(posedge clk);
            k++;
        end
        p += k;
        `CHK(k < 200, 1'b1)
        if (k >= 200) finish_test();
    endtask : wait_lvl

    // skip two full periods so pending ratio changes settle
    task automatic period(input int s);
        repeat (2) begin
            wait_lvl(s, 1'b0);
            wait_lvl(s, 1'b1);
        end
        p = 0;
        wait_lvl(s, 1'b0);
        wait_lvl(s, 1'b1);
    endtask : period

    ////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, fails, n_tests} = '0;
        sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        // register values after reset; csr status bits masked
        foreach (offs[i]) begin
            apb(1'b0, offs[i], 32'h0);
            `CHK(rd & ((i == 0) ? 32'hFFFFFF9F : 32'hFFFFFFFF), rvals[i])
        end
        // unmapped and misaligned places refused
        apb(1'b0, 8'h20, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, 8'h02, 32'hFFFFFFFF);
        `CHK(err, 1'b1)
        // bypass periods: core, mem clock, bus pin, osc pin, mem pin, pll reference clock
        foreach (psel_t[i]) begin
            period(psel_t[i]);
            `CHK(p, pexp_t[i])
        end
        // each pin gate off then on again
        foreach (goff[i]) begin
            apb(1'b1, goff[i], gval[i]);
            wait_lvl(6 + i, 1'b0);
            repeat (3) @(posedge clk);
            `CHK(watch[3 + i], 1'b0)
            apb(1'b1, goff[i], grest[i]);
            wait_lvl(6 + i, 1'b1);
        end
        // external memory clock source; reserved bits stay zero
        apb(1'b1, pcg_pkg::OFF_DEVICE_CONFIG, 32'hFFFFFFFF);
        apb(1'b0, pcg_pkg::OFF_DEVICE_CONFIG, 32'h0);
        `CHK(rd, 32'h10)
        period(5);
        `CHK(p, 10)
        // pll reset held six cycles, released in bypass
        apb(1'b1, pcg_pkg::OFF_PLL_CSR, 32'h8);
        repeat (6) @(posedge clk);
        apb(1'b1, pcg_pkg::OFF_PLL_CSR, 32'h0);
        period(0);
        `CHK(p, 2)
        repeat (LOCK + 5) @(posedge clk);
        apb(1'b0, pcg_pkg::OFF_PLL_CSR, 32'h0);
        `CHK(rd[6:5], 2'b11)
        apb(1'b1, pcg_pkg::OFF_PLL_CSR, 32'h1);
        period(0);
        `CHK(p, 2 * GAP)
        period(1);
        `CHK(p, 4 * GAP)
        // slow both dividers, bus register first, enables kept set
        apb(1'b1, pcg_pkg::OFF_PERIPH_DIV, 32'h8003);
        apb(1'b1, pcg_pkg::OFF_CORE_DIV, 32'h8001);
        period(0);
        `CHK(p, 4 * GAP)
        period(1);
        `CHK(p, 8 * GAP)
        // second reset in mid-run puts pll back in reset and bypass
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, pcg_pkg::OFF_PLL_CSR, 32'h0);
        `CHK(rd & 32'h9, 32'h8)
        finish_test();
    end
endmodule : pcg_top_bench
